// >>> core/gxp_top.sv
`timescale 1ns/10ps
module gxp_top #(
  parameter logic [3:0] ADDR_HI = gxp_pkg::ADDR_FIXED
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input wire logic [2:0] addr_i,
  input wire logic [15:0] port_i,
  output logic [15:0] port_o,
  output logic [15:0] port_oe_n,
  output logic int_n
);
  gxp_reg_if rif ();
  gxp_pkg::gxp_state_t state_q;
  gxp_pkg::gxp_phase_t phase_q;
  logic scl_q;
  logic sda_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic rd_q;
  logic ack_q;
  logic [2:0] ptr_q;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic addr_match;
  logic cmd_load;
  logic rd_ack_rise;

  gxp_regs u_regs (
    .clock(clock),
    .resetn(resetn),
    .rif(rif.regs),
    .port_i(port_i),
    .port_o(port_o),
    .port_oe_n(port_oe_n),
    .int_n(int_n)
  );

  // Previous bus levels for edge and condition detection
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  assign scl_rise = scl_i && !scl_q;
  assign scl_fall = !scl_i && scl_q;
  assign start_c = scl_i && scl_q && sda_q && !sda_i;
  assign stop_c = scl_i && scl_q && !sda_q && sda_i;
  assign addr_match = sh_q[7:1] == {ADDR_HI, addr_i};

  // Byte-level actions, all on the rising clock of the ack bit
  assign cmd_load = scl_rise && state_q == gxp_pkg::ST_RX_ACK &&
                    phase_q == gxp_pkg::PH_CMD;
  assign rd_ack_rise = scl_rise && state_q == gxp_pkg::ST_TX_ACK;
  assign rif.wr_en = scl_rise && state_q == gxp_pkg::ST_RX_ACK &&
                     phase_q == gxp_pkg::PH_DATA;
  assign rif.wdata = sh_q;
  assign rif.ptr = ptr_q;
  // Capture on address ack of a read and on each master ack or nack
  assign rif.cap = rd_ack_rise ||
                   (scl_rise && state_q == gxp_pkg::ST_RX_ACK &&
                    phase_q == gxp_pkg::PH_ADDR && sh_q[0]);

  // Pointer: loaded by command, bit 0 flips after each data byte.
  // Starts do not touch it, so a new read resumes in the pair.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ptr_q <= gxp_pkg::PTR_RST;
    end else if (cmd_load) begin
      ptr_q <= sh_q[2:0];
    end else if (rif.wr_en || rd_ack_rise) begin
      ptr_q[0] <= ~ptr_q[0];
    end
  end

  // Bus state machine; start and stop override any state
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q <= gxp_pkg::ST_IDLE;
      phase_q <= gxp_pkg::PH_ADDR;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      rd_q <= 1'b0;
      ack_q <= 1'b0;
    end else if (start_c) begin
      state_q <= gxp_pkg::ST_RX;
      phase_q <= gxp_pkg::PH_ADDR;
      cnt_q <= 4'h0;
      rd_q <= 1'b0;
    end else if (stop_c) begin
      state_q <= gxp_pkg::ST_IDLE;
    end else begin
      case (state_q)
        gxp_pkg::ST_RX: begin
          if (scl_rise) begin
            sh_q <= {sh_q[6:0], sda_i};
            cnt_q <= cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == gxp_pkg::BITS_PER_BYTE) begin
            // Another slave's address: stay off the bus until next start
            if (phase_q == gxp_pkg::PH_ADDR && !addr_match) begin
              state_q <= gxp_pkg::ST_IDLE;
            end else begin
              state_q <= gxp_pkg::ST_RX_ACK;
            end
          end
        end
        gxp_pkg::ST_RX_ACK: begin
          if (scl_rise && phase_q == gxp_pkg::PH_ADDR) begin
            rd_q <= sh_q[0];
          end
          if (scl_fall) begin
            cnt_q <= 4'h0;
            if (rd_q) begin
              state_q <= gxp_pkg::ST_TX;
              sh_q <= rif.rdata;
            end else begin
              state_q <= gxp_pkg::ST_RX;
              phase_q <= (phase_q == gxp_pkg::PH_ADDR) ? gxp_pkg::PH_CMD
                                                       : gxp_pkg::PH_DATA;
            end
          end
        end
        gxp_pkg::ST_TX: begin
          if (scl_fall) begin
            if (cnt_q == gxp_pkg::LAST_TX_BIT) begin
              state_q <= gxp_pkg::ST_TX_ACK;
            end else begin
              sh_q <= {sh_q[6:0], 1'b0};
              cnt_q <= cnt_q + 4'h1;
            end
          end
        end
        gxp_pkg::ST_TX_ACK: begin
          if (scl_rise) begin
            ack_q <= !sda_i;
          end
          if (scl_fall) begin
            cnt_q <= 4'h0;
            if (ack_q) begin
              state_q <= gxp_pkg::ST_TX;
              sh_q <= rif.rdata;
            end else begin
              state_q <= gxp_pkg::ST_IDLE;
            end
          end
        end
        default: state_q <= gxp_pkg::ST_IDLE;
      endcase
    end
  end

  // Open drain: only ever pull low, for our ack or a zero data bit
  assign sda_o = 1'b0;
  assign sda_oe_n = !(state_q == gxp_pkg::ST_RX_ACK ||
                      (state_q == gxp_pkg::ST_TX && !sh_q[7]));

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence s_cmd_ack;
    cmd_load;
  endsequence

  sequence s_read_ack;
    rd_ack_rise;
  endsequence

  property p_cmd_load;
    s_cmd_ack |=> ptr_q == $past(sh_q[2:0]);
  endproperty
  a_cmd_load: assert property (p_cmd_load)
    else $error("command byte not loaded into pointer");

  property p_write_flip;
    rif.wr_en |=> ptr_q == {$past(ptr_q[2:1]), !$past(ptr_q[0])};
  endproperty
  a_write_flip: assert property (p_write_flip)
    else $error("pointer did not alternate after write byte");

  property p_read_flip;
    s_read_ack |=> ptr_q[0] != $past(ptr_q[0]) && $stable(ptr_q[2:1]);
  endproperty
  a_read_flip: assert property (p_read_flip)
    else $error("pointer did not alternate after read byte");

  property p_read_cap;
    s_read_ack |-> rif.cap;
  endproperty
  a_read_cap: assert property (p_read_cap)
    else $error("no capture at read acknowledge clock");

  property p_first_byte;
    state_q == gxp_pkg::ST_RX_ACK && rd_q && scl_fall
    |=> state_q == gxp_pkg::ST_TX && sh_q == $past(rif.rdata);
  endproperty
  a_first_byte: assert property (p_first_byte)
    else $error("first read byte not from selected register");

  property p_start_keeps_ptr;
    start_c |=> $stable(ptr_q) ##1 state_q != gxp_pkg::ST_IDLE || stop_c;
  endproperty
  a_start_keeps_ptr: assert property (p_start_keeps_ptr)
    else $error("start changed the register pointer");

  property p_pair_kept;
    state_q == gxp_pkg::ST_RX && phase_q == gxp_pkg::PH_DATA
    |=> $stable(ptr_q[2:1]);
  endproperty
  a_pair_kept: assert property (p_pair_kept)
    else $error("write data moved the pointer out of its pair");

  property p_ack_drive;
    state_q == gxp_pkg::ST_RX_ACK |-> !sda_oe_n && !sda_o;
  endproperty
  a_ack_drive: assert property (p_ack_drive)
    else $error("byte not acknowledged by pulling data low");
endmodule

// >>> core/gxp_pkg.sv
// Behaviour
// - Command byte loads the pointer; first data byte goes to that register.
// - Registers form four pairs; next byte goes to the other pair member.
// - Any number of write bytes alternate within the pair, others untouched.
// - First read byte comes from the register the pointer selects.
// - Each further read byte comes from the other register of the pair.
// - Pointer keeps its alternated value across later start or restart.
// - Port data is captured on the rising edge of the acknowledge clock.
// - Reset puts all registers and the bus state machine to defaults.
// - Input registers show pin levels through the polarity register whatever the direction, read-only.
// - Output registers read back the written value, not the pin level.
// - Direction bit 1 makes the pin an input, 0 an output.
// - Pending interrupt clears at the acknowledge bit of a read.
package gxp_pkg;
  localparam int PTR_W = 3;
  localparam int BYTE_W = 8;
  localparam int PORT_W = 16;
  // Pair codes are pointer bits 2:1; bit 0 selects port 0 or 1
  localparam logic [1:0] PAIR_IN = 2'h0;
  localparam logic [1:0] PAIR_OUT = 2'h1;
  localparam logic [1:0] PAIR_POL = 2'h2;
  localparam logic [1:0] PAIR_CFG = 2'h3;
  localparam logic [2:0] REG_IN0 = 3'h0;
  localparam logic [2:0] REG_CFG0 = 3'h6;
  localparam logic [2:0] PTR_RST = 3'h0;
  localparam logic [7:0] OUT_RST = 8'hff;
  localparam logic [7:0] POL_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'hff;
  // Fixed upper slave address bits; value is a plain default
  localparam logic [3:0] ADDR_FIXED = 4'h4;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX = 3'b001,
    ST_RX_ACK = 3'b010,
    ST_TX = 3'b011,
    ST_TX_ACK = 3'b100
  } gxp_state_t;
  typedef enum logic [1:0] {
    PH_ADDR = 2'b00,
    PH_CMD = 2'b01,
    PH_DATA = 2'b10
  } gxp_phase_t;
endpackage

// >>> core/gxp_reg_if.sv
`timescale 1ns/10ps
interface gxp_reg_if;
  logic wr_en;
  logic [2:0] ptr;
  logic [7:0] wdata;
  logic cap;
  logic [7:0] rdata;
  modport ctl (output wr_en, output ptr, output wdata, output cap,
               input rdata);
  modport regs (input wr_en, input ptr, input wdata, input cap,
                output rdata);
endinterface

// >>> core/gxp_regs.sv
`timescale 1ns/10ps
module gxp_regs (
  input wire logic clock,
  input wire logic resetn,
  gxp_reg_if.regs rif,
  input wire logic [15:0] port_i,
  output logic [15:0] port_o,
  output logic [15:0] port_oe_n,
  output logic int_n
);
  logic [1:0][7:0] out_q;
  logic [1:0][7:0] pol_q;
  logic [1:0][7:0] cfg_q;
  logic [15:0] in_q;
  logic [15:0] in_now;
  logic init_q;
  logic int_n_q;
  logic [7:0] rdata_q;

  // Pins seen through the polarity inversion
  assign in_now = port_i ^ pol_q;

  // Register writes; the input pair has no storage to write
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      out_q <= {2{gxp_pkg::OUT_RST}};
      pol_q <= {2{gxp_pkg::POL_RST}};
      cfg_q <= {2{gxp_pkg::CFG_RST}};
    end else if (rif.wr_en) begin
      case (rif.ptr[2:1])
        gxp_pkg::PAIR_OUT: out_q[rif.ptr[0]] <= rif.wdata;
        gxp_pkg::PAIR_POL: pol_q[rif.ptr[0]] <= rif.wdata;
        gxp_pkg::PAIR_CFG: cfg_q[rif.ptr[0]] <= rif.wdata;
        default: ;
      endcase
    end
  end

  // Input snapshot; a first capture after reset avoids a false interrupt
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      in_q <= 16'h0000;
      init_q <= 1'b0;
    end else begin
      init_q <= 1'b1;
      if (!init_q || rif.cap) begin
        in_q <= in_now;
      end
    end
  end

  // Read data from a flop; lags the pointer by one clock
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
    end else begin
      case (rif.ptr[2:1])
        gxp_pkg::PAIR_IN: rdata_q <= rif.ptr[0] ? in_q[15:8] : in_q[7:0];
        gxp_pkg::PAIR_OUT: rdata_q <= out_q[rif.ptr[0]];
        gxp_pkg::PAIR_POL: rdata_q <= pol_q[rif.ptr[0]];
        default: rdata_q <= cfg_q[rif.ptr[0]];
      endcase
    end
  end

  // Only pins set as inputs may raise the interrupt.
  // Held off until the first snapshot, else a reset with pins away
  // from the snapshot reset value would flag a false interrupt.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      int_n_q <= 1'b1;
    end else begin
      int_n_q <= !init_q || ~|((in_now ^ in_q) & cfg_q);
    end
  end

  assign rif.rdata = rdata_q;
  assign port_o = out_q;
  assign port_oe_n = cfg_q;
  assign int_n = int_n_q;

  property p_input_write_ignored;
    @(posedge clock) disable iff (!resetn)
      rif.wr_en && rif.ptr[2:1] == gxp_pkg::PAIR_IN
      |=> $stable(out_q) && $stable(pol_q) && $stable(cfg_q);
  endproperty
  a_input_write_ignored: assert property (p_input_write_ignored)
    else $error("write to input register changed storage");

  property p_direction;
    @(posedge clock) disable iff (!resetn)
      rif.wr_en && rif.ptr == gxp_pkg::REG_CFG0
      |=> port_oe_n[7:0] == $past(rif.wdata);
  endproperty
  a_direction: assert property (p_direction)
    else $error("direction write did not reach the pin enables");

  property p_int_clear;
    @(posedge clock) disable iff (!resetn)
      rif.cap ##1 ($stable(port_i) && $stable(pol_q)) |=> int_n;
  endproperty
  a_int_clear: assert property (p_int_clear)
    else $error("interrupt not cleared after acknowledge capture");

  property p_capture;
    @(posedge clock) disable iff (!resetn)
      rif.cap |=> in_q == $past(in_now);
  endproperty
  a_capture: assert property (p_capture)
    else $error("port data not captured at acknowledge clock");
endmodule

// >>> verification/gxp_master.sv
`timescale 1ns/10ps
// Bus master model; phases last 4 clocks, the data hold after each clock fall 1, so the device sees each level
module gxp_master (
  input wire logic clock,
  input wire logic sda_w,
  output logic scl,
  output logic sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Start or repeated start: data falls while the clock is high
  task automatic bus_start();
    sda <= 1'b1;
    tk(4);
    scl <= 1'b1;
    tk(4);
    sda <= 1'b0;
    tk(4);
    scl <= 1'b0;
    tk(4);
  endtask
  task automatic bus_stop();
    sda <= 1'b0;
    tk(4);
    scl <= 1'b1;
    tk(4);
    sda <= 1'b1;
    tk(4);
  endtask
  // Sample mid-high, after the wire has settled, to avoid an edge race
  task automatic bit_x(input logic b, output logic r);
    sda <= b;
    tk(4);
    scl <= 1'b1;
    tk(2);
    #1 r = sda_w;
    tk(2);
    scl <= 1'b0;
    tk(1);
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask
  // The final byte is left unacknowledged
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(last, r);
  endtask
endmodule

// >>> verification/gpio_expander_register_pair_access_test.sv
`timescale 1ns/10ps
module gpio_expander_register_pair_access_test;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] addr_i = 3'h0;
  logic [15:0] port_i = 16'h0000;
  logic scl, sda_m, sda_o, sda_oe_n, int_n, ack;
  logic [15:0] port_o, port_oe_n;
  logic [7:0] mem [8];
  logic [7:0] got;
  logic [2:0] ptr;
  int err_total = 0;
  int checked = 0;
  int seed = 3;
  wire sda_w;
  // Pulled-up wire: low when either party pulls it down
  assign sda_w = sda_m & (sda_oe_n | sda_o);
  always #50 clock = ~clock;
  gxp_top gxp_top_i (.clock(clock), .resetn(resetn), .scl_i(scl),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .addr_i(addr_i),
    .port_i(port_i), .port_o(port_o), .port_oe_n(port_oe_n),
    .int_n(int_n));
  gxp_master gxp_master_i (.clock(clock), .sda_w(sda_w), .scl(scl),
    .sda(sda_m));
  task automatic cmp_val(input string nm, input logic [15:0] e,
                         input logic [15:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_flag(input string nm, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask
  // Input registers read pins through the polarity register
  function automatic logic [7:0] exp_rd(input logic [2:0] p);
    if (p[2:1] == 2'h0) return port_i[8*p[0] +: 8] ^ mem[{2'h2, p[0]}];
    return mem[p];
  endfunction
  function automatic logic [7:0] adr(input logic rd);
    return {gxp_pkg::ADDR_FIXED, addr_i, rd};
  endfunction
  task automatic rst();
    resetn <= 1'b0;
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    for (int i = 0; i < 8; i++) mem[i] = (i / 2 == 2) ? 8'h00 : 8'hff;
    ptr = 3'h0;
    repeat (2) @(posedge clock);
    // Look after the edge has settled, not in its own time step
    #1;
    cmp_val("port out", 16'hffff, port_o);
    cmp_val("direction", 16'hffff, port_oe_n);
    cmp_flag("int", 1'b1, int_n);
    cmp_flag("sda enable", 1'b1, sda_oe_n);
  endtask
  // Write transfer, mirrored in the model
  task automatic wr(input logic [2:0] cmd, input int n, input logic rnd,
                    input logic [7:0] dv);
    logic [7:0] d;
    gxp_master_i.bus_start();
    gxp_master_i.wr_byte(adr(1'b0), ack);
    cmp_flag("addr ack", 1'b1, ack);
    gxp_master_i.wr_byte({5'h00, cmd}, ack);
    ptr = cmd;
    repeat (n) begin
      d = rnd ? 8'($random(seed)) : dv;
      gxp_master_i.wr_byte(d, ack);
      cmp_flag("data ack", 1'b1, ack);
      if (ptr[2:1] != 2'h0) mem[ptr] = d;
      ptr[0] = ~ptr[0];
    end
    gxp_master_i.bus_stop();
    cmp_val("port out", {mem[3], mem[2]}, port_o);
    cmp_val("direction", {mem[7], mem[6]}, port_oe_n);
  endtask
  // Read transfer; without a command it resumes where the pointer stands
  task automatic rd(input logic [2:0] cmd, input logic aim, input int n);
    if (aim) begin
      gxp_master_i.bus_start();
      gxp_master_i.wr_byte(adr(1'b0), ack);
      gxp_master_i.wr_byte({5'h00, cmd}, ack);
      ptr = cmd;
    end
    gxp_master_i.bus_start();
    gxp_master_i.wr_byte(adr(1'b1), ack);
    for (int i = 0; i < n; i++) begin
      gxp_master_i.rd_byte(i == n - 1, got);
      cmp_val("read", {8'h00, exp_rd(ptr)}, {8'h00, got});
      ptr[0] = ~ptr[0];
    end
    gxp_master_i.bus_stop();
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    addr_i <= 3'($random(seed));
    rst();
    gxp_master_i.bus_start();
    gxp_master_i.wr_byte(adr(1'b0) ^ 8'h02, ack);
    cmp_flag("foreign addr ack", 1'b0, ack);
    gxp_master_i.bus_stop();
    $display("test reset and refusal done");
    for (int c = 0; c < 8; c++) wr(c[2:0], 1 + c % 4, 1'b1, 8'h00);
    $display("test writes done");
    // Every register with random pins, then a resume across a start
    for (int c = 0; c < 8; c++) begin
      port_i <= 16'($random(seed));
      rd(c[2:0], 1'b1, 3);
      rd(3'h0, 1'b0, 2);
    end
    $display("test reads done");
    // All pins inputs; a pin change raises the interrupt, a read clears it
    wr(3'h6, 2, 1'b0, 8'hff);
    rd(3'h0, 1'b1, 2);
    cmp_flag("int idle", 1'b1, int_n);
    port_i <= port_i ^ 16'h0101;
    for (int i = 0; i < 20 && int_n !== 1'b0; i++) @(posedge clock);
    cmp_flag("int set", 1'b0, int_n);
    rd(3'h1, 1'b1, 2);
    repeat (3) @(posedge clock);
    cmp_flag("int clear", 1'b1, int_n);
    $display("test interrupt done");
    // Reset in mid-run returns defaults and the pointer to zero
    rst();
    rd(3'h0, 1'b0, 1);
    $display("test second reset done");
    give_verdict();
  end
endmodule
